// [hdl/ifsw_top.v]
`include "ifsw_defs.vh"
`default_nettype none

module ifsw_top (
  input  wire        i_ref_clk,
  input  wire        i_rstn,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  input  wire [3:0]  i_pstrb,
  output wire        o_pready,
  output reg  [31:0] o_prdata,
  output wire        o_pslverr,
  input  wire        i_pwm_gen_two_irq,
  input  wire        i_pwm_gen_one_irq,
  input  wire        i_conv_pair_eight_done,
  input  wire        i_conv_pair_nine_done,
  input  wire        i_conv_pair_ten_done,
  input  wire        i_conv_pair_eleven_done,
  input  wire        i_conv_pair_twelve_done,
  output wire [15:0] o_irq_flags_pwm_adc_pairs
);

  // Widths of the flag word, the bus data and the bus address
  localparam WORD_W = `IFSW_WORD_W;
  localparam BUS_W  = 32;
  localparam ADDR_W = `IFSW_ADDR_W;
  localparam PAD_W  = BUS_W - WORD_W;
  localparam LANE_W = 8;

  // PWM generator flag positions
  localparam BIT_PWM_TWO     = `IFSW_PWM_TWO_BIT;
  localparam BIT_PWM_ONE     = `IFSW_PWM_ONE_BIT;

  // Conversion pair flag positions
  localparam BIT_PAIR_TWELVE = `IFSW_PAIR_TWELVE_BIT;
  localparam BIT_PAIR_ELEVEN = `IFSW_PAIR_ELEVEN_BIT;
  localparam BIT_PAIR_TEN    = `IFSW_PAIR_TEN_BIT;
  localparam BIT_PAIR_NINE   = `IFSW_PAIR_NINE_BIT;
  localparam BIT_PAIR_EIGHT  = `IFSW_PAIR_EIGHT_BIT;

  // Reset synchroniser stages
  reg               rst_meta_ff;
  reg               rst_sync_ff;

  // Event sources mapped onto the word
  reg  [WORD_W-1:0] set_vec;

  // Flag word, its mask and its write path
  wire [WORD_W-1:0] flags;
  wire [WORD_W-1:0] impl_mask;
  wire [WORD_W-1:0] wdata;
  // Byte lanes of a write
  wire [LANE_W-1:0] wlane_lo;
  wire [LANE_W-1:0] wlane_hi;
  wire              wr_en;

  // APB phase decode
  wire              hit;
  wire              setup_phase;
  wire              access;
  wire              rd_setup;
  wire              wr_access;

  // Read data path
  wire [BUS_W-1:0]  rd_word;
  reg  [BUS_W-1:0]  nxt_prdata;

  // True when a byte address selects the flag word
  function addr_hit;
    input [ADDR_W-1:0] addr;
    begin
      addr_hit = (addr == `IFSW_FLAGS_ADDR);
    end
  endfunction

  // One byte lane: new data where its strobe is set, else the held byte
  function [LANE_W-1:0] lane_merge;
    input              strobe;
    input [LANE_W-1:0] new_byte;
    input [LANE_W-1:0] old_byte;
    begin
      if (strobe) begin
        lane_merge = new_byte;
      end else begin
        lane_merge = old_byte;
      end
    end
  endfunction

  // Flag word zero-extended onto the bus; unmapped reads return zero
  function [BUS_W-1:0] read_word;
    input              sel;
    input [WORD_W-1:0] word;
    begin
      if (sel) begin
        read_word = {{PAD_W{1'b0}}, word};
      end else begin
        read_word = {BUS_W{1'b0}};
      end
    end
  endfunction

  // Place each event source at its flag position
  function [WORD_W-1:0] map_sources;
    input pwm_two;
    input pwm_one;
    input pair_twelve;
    input pair_eleven;
    input pair_ten;
    input pair_nine;
    input pair_eight;
    begin
      // Unimplemented positions stay zero
      map_sources                  = {WORD_W{1'b0}};
      // PWM generator requests
      map_sources[BIT_PWM_TWO]     = pwm_two;
      map_sources[BIT_PWM_ONE]     = pwm_one;
      // Conversion pair completions
      map_sources[BIT_PAIR_TWELVE] = pair_twelve;
      map_sources[BIT_PAIR_ELEVEN] = pair_eleven;
      map_sources[BIT_PAIR_TEN]    = pair_ten;
      map_sources[BIT_PAIR_NINE]   = pair_nine;
      map_sources[BIT_PAIR_EIGHT]  = pair_eight;
    end
  endfunction

  // Reset release through two flops
  always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Map event sources onto flag positions
  always @* begin
    // Arguments run from bit 15 down to bit 1
    set_vec = map_sources(
      i_pwm_gen_two_irq,
      i_pwm_gen_one_irq,
      i_conv_pair_twelve_done,
      i_conv_pair_eleven_done,
      i_conv_pair_ten_done,
      i_conv_pair_nine_done,
      i_conv_pair_eight_done
    );
  end

  // Bus phases
  assign hit         = addr_hit(i_paddr);
  assign setup_phase = i_psel & ~i_penable;
  assign access      = i_psel & i_penable;
  // A read setup cycle loads the read data
  assign rd_setup    = setup_phase & ~i_pwrite;
  // A write lands in its access phase
  assign wr_access   = access & i_pwrite;

  // Zero-wait slave: ready in the first access cycle
  assign o_pready  = access;
  // Unmapped addresses report an error and change nothing
  assign o_pslverr = access & ~hit;
  // Write lands only on a mapped access
  assign wr_en     = wr_access & hit;

  // Byte lanes merge into the held value; upper lanes carry nothing
  assign wlane_lo  = lane_merge(i_pstrb[0], i_pwdata[7:0], flags[7:0]);
  assign wlane_hi  = lane_merge(i_pstrb[1], i_pwdata[15:8], flags[15:8]);
  assign wdata     = {wlane_hi, wlane_lo};
  // Only implemented positions can ever hold a one
  assign impl_mask = `IFSW_IMPL_MASK;

  // Flag word, unimplemented bits held at zero
  ifsw_flag_reg #(
    .WIDTH (`IFSW_WORD_W)
  ) u_flags (
    .i_clk   (i_ref_clk),
    .i_rst_n (rst_sync_ff),
    .i_mask  (impl_mask),
    .i_set   (set_vec),
    .i_wr    (wr_en),
    .i_wdata (wdata),
    .o_flags (flags)
  );

  // Word offered to a read, flags as they stand in the setup cycle
  assign rd_word = read_word(hit, flags);

  // Read data registered in the setup cycle, held until the next read
  always @* begin
    nxt_prdata = o_prdata;
    if (rd_setup) begin
      nxt_prdata = rd_word;
    end
  end

  // Read data register; cleared while the block is in reset
  always @(posedge i_ref_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      o_prdata <= 32'h00000000;
    end else begin
      o_prdata <= nxt_prdata;
    end
  end

  // Flag word pins follow the register
  assign o_irq_flags_pwm_adc_pairs = flags;

endmodule

`default_nettype wire

// [hdl/ifsw_defs.vh]
`ifndef IFSW_DEFS_VH
`define IFSW_DEFS_VH

// Register byte address on the APB
`define IFSW_FLAGS_ADDR      12'h000
`define IFSW_ADDR_W          12

// Flag bit positions
`define IFSW_PWM_TWO_BIT     15
`define IFSW_PWM_ONE_BIT     14
`define IFSW_PAIR_TWELVE_BIT 13
`define IFSW_PAIR_ELEVEN_BIT 4
`define IFSW_PAIR_TEN_BIT    3
`define IFSW_PAIR_NINE_BIT   2
`define IFSW_PAIR_EIGHT_BIT  1

// Implemented bit mask and reset value
`define IFSW_IMPL_MASK       16'hE01E
`define IFSW_FLAGS_RST       16'h0000
`define IFSW_WORD_W          16

`endif

// [hdl/ifsw_flag_reg.v]
`include "ifsw_defs.vh"
`default_nettype none

// Sticky flag word: hardware set wins over software write
module ifsw_flag_reg #(
  parameter WIDTH = 16
) (
  input  wire             i_clk,
  input  wire             i_rst_n,
  input  wire [WIDTH-1:0] i_mask,
  input  wire [WIDTH-1:0] i_set,
  input  wire             i_wr,
  input  wire [WIDTH-1:0] i_wdata,
  output wire [WIDTH-1:0] o_flags
);

  reg  [WIDTH-1:0] flags_ff;
  reg  [WIDTH-1:0] nxt_flags;

  // Write replaces, pending set events then OR in
  always @* begin
    nxt_flags = flags_ff;
    if (i_wr) begin
      nxt_flags = i_wdata;
    end
    nxt_flags = (nxt_flags | i_set) & i_mask;
  end

  // Flag storage
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_ff <= {WIDTH{1'b0}};
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign o_flags = flags_ff;

endmodule

`default_nettype wire

// [testbench/ifsw_monitor.sv]
`default_nettype none
// Flag word checks against sources and bus writes
module ifsw_monitor (
  input wire logic        i_ref_clk,
  input wire logic        i_rstn,
  input wire logic        i_pwrite,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic        o_pslverr,
  input wire logic        i_pwm_gen_two_irq,
  input wire logic        i_conv_pair_nine_done,
  input wire logic        i_conv_pair_twelve_done,
  input wire logic [15:0] o_irq_flags_pwm_adc_pairs
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [15:0] f = o_irq_flags_pwm_adc_pairs;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  a_pair_twelve: assert property ($past(i_rstn, 2) && i_conv_pair_twelve_done |=> f[13]) else $error("p12");
  a_flag_hold: assert property (!i_pwrite |=> (f & $past(f)) == $past(f)) else $error("drop");
  a_reset_zero: assert property (!$past(i_rstn) |-> f == 16'h0000) else $error("rst");
  a_unimpl_zero: assert property ((f & 16'h1FE1) == 16'h0000) else $error("bits");
  a_pair_nine: assert property ($past(i_rstn, 2) && i_conv_pair_nine_done |=> f[2]) else $error("p9");
  a_pwm_two: assert property ($past(i_rstn, 2) && i_pwm_gen_two_irq |=> f[15]) else $error("pwm2");
  a_unmapped_err: assert property (i_psel && i_penable |-> o_pslverr == (i_paddr != 12'h000)) else $error("err");
endmodule
`default_nettype wire

// [testbench/ifsw_src_model.sv]
`default_nettype none
// Event sources: request bits drive the sources one clock later
module ifsw_src_model (
  input  wire logic       i_clk,
  input  wire logic [6:0] i_req,
  output var  logic [6:0] o_src
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge i_clk) o_src <= i_req;
endmodule
`default_nettype wire

// [testbench/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rstn = 1'b0, ps = 1'b0, pe = 1'b0, pw = 1'b0, rdy;
  logic [11:0] pa = 12'h000;
  logic [31:0] wd = 32'h0, rd;
  logic [6:0]  q = 7'h00, s;
  logic [3:0]  stb = 4'hF;
  logic [15:0] fl;
  logic        err;
  int          fail_count = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  ifsw_src_model far (.i_clk(clk), .i_req(q), .o_src(s));
  ifsw_top dut (.i_ref_clk(clk), .i_rstn(rstn), .i_psel(ps), .i_penable(pe), .i_pwrite(pw), .i_paddr(pa),
    .i_pwdata(wd), .i_pstrb(stb), .o_pready(rdy), .o_prdata(rd), .o_pslverr(err), .i_pwm_gen_two_irq(s[6]),
    .i_pwm_gen_one_irq(s[5]), .i_conv_pair_eight_done(s[0]), .i_conv_pair_nine_done(s[1]),
    .i_conv_pair_ten_done(s[2]), .i_conv_pair_eleven_done(s[3]), .i_conv_pair_twelve_done(s[4]),
    .o_irq_flags_pwm_adc_pairs(fl));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, e);
    {ps, pw, pa, wd} <= {1'b1, w, a, d};
    @(posedge clk);
    pe <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    cmp_count += 1 + !w;
    if (err !== (a != 12'h000)) begin
      fail_count++;
      $display("Error %0t slverr %h exp %h", $time, err, a != 12'h000);
    end
    if (!w && rd !== e) begin
      fail_count++;
      $display("Error %0t got %h exp %h", $time, rd, e);
    end
    {ps, pe} <= 2'h0;
    @(posedge clk);
  endtask
  // Each source sets its own bit, which holds until written off
  task automatic t_src();
    logic [31:0] e;
    for (int i = 0; i < 7; i++) begin
      q <= 7'h01 << i;
      @(posedge clk);
      q <= 7'h00;
      repeat (2) @(posedge clk);
      e = 32'h1 << (i < 4 ? i + 1 : i + 9);
      cmp_count++;
      if (fl !== e[15:0]) begin
        fail_count++;
        $display("Error %0t flags %h exp %h", $time, fl, e[15:0]);
      end
      apb(1'b0, 12'h000, 32'h0, e);
      apb(1'b1, 12'h000, 32'h0, 32'h0);
      apb(1'b0, 12'h000, 32'h0, 32'h0);
    end
    $display("t_src done");
  endtask
  // Only implemented bits store; unmapped writes are ignored
  task automatic t_wr();
    apb(1'b0, 12'h000, 32'h0, 32'h0);
    apb(1'b1, 12'h000, 32'hFFFFFFFF, 32'h0);
    apb(1'b1, 12'h004, 32'h0, 32'h0);
    apb(1'b0, 12'h000, 32'h0, 32'h0000E01E);
    stb <= 4'h1;
    apb(1'b1, 12'h000, 32'h0, 32'h0);
    stb <= 4'hF;
    apb(1'b0, 12'h000, 32'h0, 32'h0000E000);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, 12'h000, 32'h0, 32'h0);
    $display("t_wr done");
  endtask
  task automatic end_sim();
    $display("%0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Reset, then the scenarios
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_wr();
    apb(1'b1, 12'h000, 32'h0, 32'h0);
    t_src();
    end_sim();
  end
  // Watchdog
  initial begin
    #20us;
    fail_count++;
    end_sim();
  end
endmodule
bind ifsw_top ifsw_monitor mon (.*);
`default_nettype wire
